// ==== pssi_regs.svh ====
// Constants of the power-state and status-indication block.
// Assumes a single 250 MHz reference clock; included by the package.
`ifndef PSSI_REGS_SVH
`define PSSI_REGS_SVH
`define PSSI_CLK_MHZ 250
`define PSSI_HH_HOLD_MS 500
`define PSSI_HH_HOLD_CYC (`PSSI_HH_HOLD_MS * 1000 * `PSSI_CLK_MHZ)
`define PSSI_TRIM_W 5
`define PSSI_TRIM_RST 5'h10
`define PSSI_TRIM_MIN 5'h01
`define PSSI_BRIGHT_W 4
`define PSSI_SEQ_W 16
`define PSSI_STEP_CYC 32'h00fffff
`define PSSI_NUM_IND 6
`endif

// ==== pssi_pkg.sv ====
// Types shared by the power-state and status-indication block.
// Assumes pssi_regs.svh for widths.
`include "pssi_regs.svh"
package pssi_pkg;
  typedef enum logic [2:0] {
    PSSI_ST_DEEP = 3'h0,
    PSSI_ST_POWERON = 3'h1,
    PSSI_ST_STANDBY = 3'h2,
    PSSI_ST_LIGHT = 3'h3,
    PSSI_ST_ACCESS = 3'h4,
    PSSI_ST_LINK = 3'h5
  } pssi_state_t;
  typedef enum logic [1:0] {
    PSSI_MODE_APP = 2'h0,
    PSSI_MODE_NVWR = 2'h1,
    PSSI_MODE_FWWR = 2'h2
  } pssi_mode_t;
  // Indicator conditions, one bit each: standby, linkback, lowbat, inquiry, link, page
  typedef struct packed {
    logic standby;
    logic link_back;
    logic low_batt;
    logic inquiry;
    logic link;
    logic page;
  } pssi_ind_t;
  // Host or automatic events that steer the state machine
  typedef struct packed {
    logic go_access;
    logic go_link;
    logic go_standby;
    logic go_light;
  } pssi_cmd_t;
endpackage : pssi_pkg

// ==== pssi_led.sv ====
// LED sequencer: plays a 16-step on/off pattern with 16-level PWM brightness.
// Assumes pattern words and brightness are stable configuration from the main block.
`timescale 1ns/1ns
`default_nettype none
module pssi_led
  import pssi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`PSSI_SEQ_W-1:0] pattern,
  input wire logic [`PSSI_BRIGHT_W-1:0] brightness,
  output logic led_on
);
  logic [31:0] step_cnt_r, step_cnt_nxt;
  logic [3:0] step_r, step_nxt;
  logic [3:0] pwm_r, pwm_nxt;
  logic led_nxt;
  // ==========================================================
  // Step timer, PWM phase and the registered LED drive
  always_comb begin
    step_cnt_nxt = step_cnt_r + 32'h1;
    step_nxt = step_r;
    pwm_nxt = pwm_r + 4'h1;
    if (step_cnt_r == `PSSI_STEP_CYC) begin
      step_cnt_nxt = 32'h0;
      step_nxt = step_r + 4'h1;
    end
    // Brightness 0 is dimmest but still visible, so compare with <=
    led_nxt = pattern[step_r] && (pwm_r <= brightness);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt_r <= 32'h0;
      step_r <= 4'h0;
      pwm_r <= 4'h0;
      led_on <= 1'b0;
    end else begin
      step_cnt_r <= step_cnt_nxt;
      step_r <= step_nxt;
      pwm_r <= pwm_nxt;
      led_on <= led_nxt;
    end
  end
  a_led_dark_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !pattern[$past(step_r)] && $stable(pattern) |-> !led_on)
    else $error("LED lit in an off step");
endmodule : pssi_led
`default_nettype wire

// ==== pssi_top.sv ====
// Power-state machine, status encoding and LED indication of the module.
// Assumes the button, wake, reset and strap pins are asynchronous to ref_clk;
// host commands and link status come from same-clock logic.
`timescale 1ns/1ns
`default_nettype none
module pssi_top
  import pssi_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ext_reset_n_in,
  input wire logic watchdog_timer_expired,
  input wire logic power_button_in,
  input wire logic wake_n_in,
  input wire logic config_strap_a,
  input wire logic config_strap_b,
  input wire logic config_strap_c,
  input wire logic nv_manual_mode,
  input wire logic nv_write_en,
  input wire logic nv_manual_wdata,
  input wire logic [`PSSI_TRIM_W-1:0] nv_trim_wdata,
  input wire logic [`PSSI_BRIGHT_W-1:0] nv_bright_wdata,
  input wire pssi_cmd_t host_cmd,
  input wire pssi_cmd_t auto_evt,
  input wire logic uart_busy,
  input wire pssi_ind_t ind_req,
  input wire logic [`PSSI_NUM_IND*`PSSI_SEQ_W-1:0] ind_patterns,
  output logic status_out_a,
  output logic status_out_b,
  output logic indicator_led_out,
  output logic [`PSSI_TRIM_W-1:0] xtal_trim,
  output pssi_mode_t op_mode,
  output logic manual_active,
  output pssi_state_t power_state
);
  // ==========================================================
  // Input synchronisers
  // Two flops each; the first stage feeds only the second.
  logic [3:0] sync1_r, sync2_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
    end else begin
      sync1_r <= {ext_reset_n_in, power_button_in, wake_n_in, 1'b1};
      sync2_r <= sync1_r;
    end
  end
  logic ext_rst_n_s, btn_s, wake_n_s;
  assign ext_rst_n_s = sync2_r[3];
  assign btn_s = sync2_r[2];
  assign wake_n_s = sync2_r[1];

  // Straps pass two flops too. No reset here: the flops keep tracking the pins
  // during reset, so the value caught on the first edge after release is real
  logic [2:0] strap1_r, strap2_r;
  always_ff @(posedge ref_clk) begin
    strap1_r <= {config_strap_a, config_strap_b, config_strap_c};
    strap2_r <= strap1_r;
  end

  // ==========================================================
  // Internal power-on reset: pin reset, external reset or watchdog
  logic por_r;
  logic por_nxt;
  always_comb begin
    por_nxt = !ext_rst_n_s || watchdog_timer_expired;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      por_r <= 1'b1;
    end else begin
      por_r <= por_nxt;
    end
  end

  // ==========================================================
  // Mode decode and nonvolatile configuration
  function automatic pssi_mode_t decode_mode(input logic [2:0] s);
    if (s == 3'b001) begin
      decode_mode = PSSI_MODE_FWWR;
    end else if (s == 3'b011 || s == 3'b010) begin
      decode_mode = PSSI_MODE_NVWR;
    end else begin
      decode_mode = PSSI_MODE_APP;
    end
  endfunction : decode_mode

  logic caught_r, caught_nxt;
  pssi_mode_t mode_r, mode_nxt;
  logic nv_manual_r, nv_manual_nxt;
  logic manual_r, manual_nxt;
  logic [`PSSI_TRIM_W-1:0] trim_r, trim_nxt;
  logic [`PSSI_BRIGHT_W-1:0] bright_r, bright_nxt;
  // Straps caught on the first cycle out of reset; later writes gated by mode
  always_comb begin
    caught_nxt = 1'b1;
    mode_nxt = mode_r;
    nv_manual_nxt = nv_manual_r;
    manual_nxt = manual_r;
    trim_nxt = trim_r;
    bright_nxt = bright_r;
    if (!caught_r) begin
      mode_nxt = decode_mode(strap2_r);
      manual_nxt = nv_manual_mode;
      nv_manual_nxt = nv_manual_mode;
    end
    if (nv_write_en && mode_r == PSSI_MODE_NVWR && caught_r) begin
      nv_manual_nxt = nv_manual_wdata;
      bright_nxt = nv_bright_wdata;
      // Code 0 is not a usable trim step
      trim_nxt = (nv_trim_wdata < `PSSI_TRIM_MIN) ? `PSSI_TRIM_MIN : nv_trim_wdata;
    end
    if (por_r) begin
      caught_nxt = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      caught_r <= 1'b0;
      mode_r <= PSSI_MODE_APP;
      nv_manual_r <= 1'b0; // Automatic machine by default
      manual_r <= 1'b0;
      trim_r <= `PSSI_TRIM_RST;
      bright_r <= 4'hf;
    end else begin
      caught_r <= caught_nxt;
      mode_r <= mode_nxt;
      nv_manual_r <= nv_manual_nxt;
      manual_r <= manual_nxt;
      trim_r <= trim_nxt;
      bright_r <= bright_nxt;
    end
  end

  // ==========================================================
  // Power state machine
  pssi_state_t state_r, state_nxt;
  pssi_cmd_t cmd;
  // Host-commanded machine ignores the automatic event source entirely
  assign cmd = manual_r ? host_cmd : auto_evt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PSSI_ST_DEEP: begin
        if (btn_s) begin
          state_nxt = PSSI_ST_POWERON;
        end
      end
      PSSI_ST_POWERON: begin
        state_nxt = PSSI_ST_STANDBY;
      end
      PSSI_ST_STANDBY: begin
        if (cmd.go_access) begin
          state_nxt = PSSI_ST_ACCESS;
        end else if (cmd.go_light) begin
          state_nxt = PSSI_ST_LIGHT;
        end
      end
      PSSI_ST_LIGHT: begin
        if (!wake_n_s || cmd.go_standby) begin
          state_nxt = PSSI_ST_STANDBY;
        end
      end
      PSSI_ST_ACCESS: begin
        if (cmd.go_link) begin
          state_nxt = PSSI_ST_LINK;
        end else if (cmd.go_standby) begin
          state_nxt = PSSI_ST_STANDBY;
        end
      end
      PSSI_ST_LINK: begin
        if (cmd.go_standby) begin
          state_nxt = PSSI_ST_STANDBY;
        end
      end
      default: begin
        state_nxt = PSSI_ST_POWERON;
      end
    endcase
    // Button low overrides all; nothing else reaches deep sleep
    if (!btn_s) begin
      state_nxt = PSSI_ST_DEEP;
    end else if (por_r) begin
      state_nxt = PSSI_ST_POWERON;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PSSI_ST_POWERON;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Status outputs: one decode, both bits registered in the same edge
  // so the host never sees a half-updated pair.
  function automatic logic [1:0] status_code(input pssi_state_t s, input logic busy);
    case (s)
      PSSI_ST_ACCESS: status_code = 2'b10;
      PSSI_ST_LINK: status_code = busy ? 2'b01 : 2'b00;
      default: status_code = 2'b11;
    endcase
  endfunction : status_code
  logic [1:0] stat_r, stat_nxt;
  always_comb begin
    stat_nxt = status_code(state_nxt, uart_busy);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= 2'b11;
    end else begin
      stat_r <= stat_nxt;
    end
  end
  assign status_out_a = stat_r[1];
  assign status_out_b = stat_r[0];

  // ==========================================================
  // LED indication: highest set condition index with a nonzero pattern wins; dark in deep sleep
  logic [`PSSI_SEQ_W-1:0] pat_sel;
  always_comb begin
    pat_sel = '0;
    for (int i = 0; i < `PSSI_NUM_IND; i++) begin
      if (ind_req[`PSSI_NUM_IND-1-i] && pat_sel == '0) begin
        pat_sel = ind_patterns[(`PSSI_NUM_IND-1-i)*`PSSI_SEQ_W +: `PSSI_SEQ_W];
      end
    end
    if (state_r == PSSI_ST_DEEP) begin
      pat_sel = '0;
    end
  end
  pssi_led u_led (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pattern(pat_sel),
    .brightness(bright_r),
    .led_on(indicator_led_out)
  );

  assign xtal_trim = trim_r;
  assign op_mode = mode_r;
  assign manual_active = manual_r;
  assign power_state = state_r;

  // ==========================================================
  // Checks
  sequence s_button_low;
    !btn_s ##1 !btn_s;
  endsequence
  a_deep_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_button_low |-> state_r == PSSI_ST_DEEP)
    else $error("Button low did not reach deep sleep");
  a_deep_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r != PSSI_ST_DEEP ##1 state_r == PSSI_ST_DEEP |-> !$past(btn_s))
    else $error("Deep sleep entered without the button");
  a_wake_light: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == PSSI_ST_LIGHT && !wake_n_s && btn_s && !por_r |=> state_r == PSSI_ST_STANDBY)
    else $error("Wake did not leave light sleep");
  a_ext_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ext_rst_n_s && btn_s |=> ##1 (state_r == PSSI_ST_POWERON || !$past(btn_s)))
    else $error("External reset did not force power-on");
  a_status_map: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_r == PSSI_ST_ACCESS |-> {status_out_a, status_out_b} == 2'b10)
    else $error("Access state shown wrongly");
  a_status_pair: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(state_r) == PSSI_ST_ACCESS && state_r == PSSI_ST_DEEP |-> {status_out_a, status_out_b} == 2'b11)
    else $error("Status pair passed through a transient");
  a_trim_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    xtal_trim >= `PSSI_TRIM_MIN)
    else $error("Trim code out of range");
  a_nv_locked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mode_r != PSSI_MODE_NVWR && caught_r && !por_r |=> $stable(bright_r) && $stable(trim_r))
    else $error("Configuration changed outside write mode");
  a_manual_cmd: assert property (@(posedge ref_clk) disable iff (!reset_n)
    manual_r && state_r == PSSI_ST_STANDBY && btn_s && !por_r && host_cmd == '0 |=> state_r == PSSI_ST_STANDBY)
    else $error("Host-commanded machine moved on its own");
endmodule : pssi_top
`default_nettype wire

// ==== pssi_host.sv ====
// Host-side model: drives the button, wake, reset and strap pins.
// Assumes the bench requests pin levels; pins move just after ref_clk rises.
`timescale 1ns/1ns
`default_nettype none
module pssi_host
  import pssi_pkg::*;
#(
  parameter int HOLD_CYC = 16
)
(
  input wire logic ref_clk,
  input wire logic btn_req,
  input wire logic wake_req,
  input wire logic rst_req,
  input wire logic [2:0] strap_req,
  input wire logic status_out_a,
  input wire logic status_out_b,
  output logic power_button_in,
  output logic wake_n_in,
  output logic ext_reset_n_in,
  output logic [2:0] straps,
  output logic hh_valid
);
  int hh_cnt;
  // ===========================================
  // Pin drive
  // Straps idle high, as the pull-ups would leave them
  initial begin
    power_button_in = 1'b1;
    wake_n_in = 1'b1;
    ext_reset_n_in = 1'b1;
    straps = 3'h7;
    hh_cnt = 0;
  end
  // Pins follow the requests one small delay after the edge
  always @(posedge ref_clk) begin
    power_button_in <= #1 btn_req;
    wake_n_in <= #1 ~wake_req;
    ext_reset_n_in <= #1 ~rst_req;
    straps <= #1 strap_req;
  end
  // ===========================================
  // Status reading
  // Both-high is trusted only once it has held long enough
  always @(posedge ref_clk) begin
    if (!(status_out_a && status_out_b)) hh_cnt <= 0;
    else if (hh_cnt < HOLD_CYC) hh_cnt <= hh_cnt + 1;
  end
  assign hh_valid = (hh_cnt >= HOLD_CYC);
endmodule : pssi_host
`default_nettype wire

// ==== pssi_top_tb.sv ====
// Self-checking bench of the power-state and status block.
// Assumes pssi_host drives the pins; outputs are compared through a queue of notes.
`timescale 1ns/1ns
`default_nettype none
module pssi_top_tb
  import pssi_pkg::*;
;
  logic ref_clk, reset_n, wd, btn_req, wake_req, rst_req, nv_manual_mode, nv_write_en, uart_busy;
  logic sa, sb, led, btn, wake_n, ext_rst_n, hh_valid, man, exp_man;
  logic [2:0] strap_req, straps;
  logic [4:0] trim_w, trim, exp_trim;
  logic [3:0] bright_w;
  logic [95:0] pats;
  pssi_cmd_t host_cmd, auto_evt;
  pssi_ind_t ind_req;
  pssi_mode_t mode, exp_mode;
  pssi_state_t st;
  logic [12:0] notes[$];
  logic [31:0] rs = 32'hf9f50ff2;
  event look;
  int miscompares = 0;
  int total_checks = 0;
  logic [2:0] sp_tab [4] = '{3'h6, 3'h1, 3'h2, 3'h3};
  pssi_mode_t md_tab [4] = '{PSSI_MODE_APP, PSSI_MODE_FWWR, PSSI_MODE_NVWR, PSSI_MODE_NVWR};

  pssi_host host (.ref_clk(ref_clk), .btn_req(btn_req), .wake_req(wake_req), .rst_req(rst_req),
    .strap_req(strap_req), .status_out_a(sa), .status_out_b(sb), .power_button_in(btn),
    .wake_n_in(wake_n), .ext_reset_n_in(ext_rst_n), .straps(straps), .hh_valid(hh_valid));

  pssi_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .ext_reset_n_in(ext_rst_n),
    .watchdog_timer_expired(wd), .power_button_in(btn), .wake_n_in(wake_n),
    .config_strap_a(straps[2]), .config_strap_b(straps[1]), .config_strap_c(straps[0]),
    .nv_manual_mode(nv_manual_mode), .nv_write_en(nv_write_en), .nv_manual_wdata(1'b0),
    .nv_trim_wdata(trim_w), .nv_bright_wdata(bright_w), .host_cmd(host_cmd), .auto_evt(auto_evt),
    .uart_busy(uart_busy), .ind_req(ind_req), .ind_patterns(pats), .status_out_a(sa),
    .status_out_b(sb), .indicator_led_out(led), .xtal_trim(trim), .op_mode(mode),
    .manual_active(man), .power_state(st));

  // ===========================================
  // Helpers
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  // Status pair expected for a state: a is the high bit
  function automatic logic [1:0] code(pssi_state_t s, logic busy);
    if (s == PSSI_ST_ACCESS) return 2'h2;
    if (s == PSSI_ST_LINK) return busy ? 2'h1 : 2'h0;
    return 2'h3;
  endfunction : code
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic check(logic [12:0] seen, logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Waits past the two sync flops and the state edge, then notes the expectation
  task automatic note(pssi_state_t s);
    repeat (6) @(posedge ref_clk);
    notes.push_back({exp_mode, exp_man, exp_trim, code(s, uart_busy), s});
    -> look;
    #1;
  endtask : note
  // Commands are one-cycle levels; lowered after an edge so no double drive
  task automatic evt(pssi_cmd_t c, logic from_host);
    cyc(1);
    if (from_host) host_cmd = c;
    else auto_evt = c;
    cyc(1);
    host_cmd = '0;
    auto_evt = '0;
  endtask : evt
  task automatic do_reset(logic [2:0] sp, logic manual);
    strap_req = sp;
    nv_manual_mode = manual;
    reset_n = 1'b0;
    cyc(8);
    reset_n = 1'b1;
    exp_trim = 5'h10;
    exp_man = manual;
  endtask : do_reset
  task automatic nv_wr(logic [4:0] t);
    trim_w = t;
    bright_w = 4'(xs());
    nv_write_en = 1'b1;
    cyc(1);
    nv_write_en = 1'b0;
  endtask : nv_wr
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // ===========================================
  // Clock, monitor and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Every observable output but the LED is folded into one compared word
  always @(look) begin
    #1;
    check({mode, man, trim, sa, sb, st}, notes.pop_front());
  end
  // Run needs well under 2000 cycles
  initial begin
    #40000;
    miscompares++;
    summarize();
  end

  // ===========================================
  // Main sequence
  initial begin
    {wd, btn_req, wake_req, rst_req, nv_write_en, uart_busy} = 6'h10;
    {host_cmd, auto_evt, trim_w, bright_w} = '0;
    ind_req = pssi_ind_t'(xs());
    pats = {xs(), xs(), xs()};
    exp_mode = PSSI_MODE_APP;
    do_reset(3'h7, 1'b0);
    note(PSSI_ST_STANDBY);
    uart_busy = 1'b1;
    evt(4'h8, 1'b0);
    note(PSSI_ST_ACCESS);
    evt(4'h4, 1'b0);
    note(PSSI_ST_LINK);
    uart_busy = 1'b0;
    note(PSSI_ST_LINK);
    wd = 1'b1;
    note(PSSI_ST_POWERON);
    wd = 1'b0;
    note(PSSI_ST_STANDBY);
    rst_req = 1'b1;
    note(PSSI_ST_POWERON);
    rst_req = 1'b0;
    note(PSSI_ST_STANDBY);
    nv_wr(5'h07);
    note(PSSI_ST_STANDBY);
    $display("test status and reset done");
    evt(4'h1, 1'b0);
    note(PSSI_ST_LIGHT);
    wake_req = 1'b1;
    note(PSSI_ST_STANDBY);
    wake_req = 1'b0;
    btn_req = 1'b0;
    note(PSSI_ST_DEEP);
    check({12'h0, led}, 13'h0);
    evt(4'h2, 1'b0);
    note(PSSI_ST_DEEP);
    btn_req = 1'b1;
    note(PSSI_ST_STANDBY);
    $display("test sleep states done");
    for (int i = 0; i < 4; i++) begin
      do_reset(sp_tab[i], 1'b0);
      exp_mode = md_tab[i];
      note(PSSI_ST_STANDBY);
    end
    // Code 0 first: the boundary that must come back as 1
    for (int k = 0; k < 4; k++) begin
      nv_wr((k == 0) ? 5'h00 : 5'(xs() % 31 + 1));
      exp_trim = (trim_w == 5'h00) ? 5'h01 : trim_w;
      note(PSSI_ST_STANDBY);
    end
    check({12'h0, hh_valid}, 13'h1);
    $display("test modes and trim done");
    do_reset(3'h7, 1'b1);
    exp_mode = PSSI_MODE_APP;
    note(PSSI_ST_STANDBY);
    evt(4'h8, 1'b0);
    note(PSSI_ST_STANDBY);
    evt(4'h8, 1'b1);
    note(PSSI_ST_ACCESS);
    check({12'h0, hh_valid}, 13'h0);
    $display("test host-commanded done");
    cyc(4);
    summarize();
  end
endmodule : pssi_top_tb
`default_nettype wire
